// ### logic/ssu_unit.sv
// safety status, start guard, cascade and event unit
// Summary of operation
// RULE1: guard request comes from the local input or the safety fieldbus
// RULE2: guard output rises in the same cycle as the request
// RULE3: completed output rises only after the configured completion delay
// RULE4: while the guard is active the drive is inhibited, starts refused
// RULE5: outputs drop after request removal plus acknowledge when manual
// RULE6: without fieldbus only dual-input functions may be cascaded
// RULE7: a master's cascaded function becomes active in every follower
// RULE8: auto-acknowledging followers clear when the master releases
// RULE9: events are reported as pure event, warning or fault
// RULE10: warnings need no reset, self-clear, and never trip the drive
// RULE11: faults trip the drive and hold until recovery is written
// RULE12: one setting classes stop requests and their completions
// RULE13: a second setting classes speed limit and ramp monitor hits
// RULE14: a third setting classes fieldbus passivation
// RULE15: run indicator off, steady or flashing by module mode
// RULE16: function indicator shows active, unacknowledged, fail-safe, config
// RULE17: fieldbus indicator off, steady or flashing by link state
`default_nettype none
module ssu_unit #(
  parameter int unsigned MS_CYCLES = ssu_pkg::MS_CYCLES,
  parameter int unsigned BLINK_HALF_MS = ssu_pkg::BLINK_HALF_MS
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [31:0] bus_rdata,
  input wire logic guard_request_input,
  input wire logic ack_button_input,
  input wire logic [3:0] func_in_a,
  input wire logic [3:0] func_in_b,
  input wire logic [4:0] cascade_in,
  output logic [4:0] cascade_out,
  input wire logic fb_guard_req,
  input wire logic [3:0] fb_func_req,
  input wire logic [1:0] fb_state,
  input wire logic fb_passivated,
  input wire logic [2:0] stop_completed,
  input wire logic [7:0] limit_hit,
  input wire logic drive_start_cmd,
  output logic guard_output,
  output logic guard_completed_output,
  output logic drive_inhibit,
  output logic start_refused,
  output logic [3:0] func_active,
  output logic event_valid,
  output logic [3:0] event_code,
  output logic [1:0] event_class,
  output logic warning_active,
  output logic drive_trip,
  output logic run_led,
  output logic fs_led_green,
  output logic fs_led_red,
  output logic fb_led
);
  localparam int unsigned MSW = $clog2(MS_CYCLES + 1);
  localparam int unsigned NS = 1 + 1 + 4 + 4 + 5;
  localparam int unsigned NUM_EV_W = ssu_pkg::NUM_EV;

  typedef struct packed {
    logic [2:0] mode;
    logic fb_present;
    logic guard_local_en;
    logic guard_fb_en;
    logic guard_ack_manual;
    logic func_ack_manual;
    logic [15:0] guard_delay;
    logic [1:0] cas_sel;
    logic [4:0] chain_mask;
    logic [1:0] cls_req;
    logic [1:0] cls_lim;
    logic [1:0] cls_pas;
    logic guard_hold;
    logic guard_done;
    logic [15:0] guard_cnt;
    logic [3:0] func_latch;
    logic ack_prev;
    logic [NUM_EV_W-1:0] cause_prev;
    logic [NUM_EV_W-1:0] pend;
    logic fault;
    logic warn;
    logic ev_valid;
    logic [3:0] ev_code;
    logic [1:0] ev_class;
    logic [4:0] cas_out;
    logic [31:0] rdata;
    logic [MSW-1:0] ms_cnt;
    logic ms_tick;
    logic [15:0] blink_cnt;
    logic blink;
  } ssu_unit_s;

  ssu_unit_s st_reg;
  ssu_unit_s st_next;

  logic [NS-1:0] pins_sync;
  logic pin_guard;
  logic pin_ack;
  logic [3:0] pin_a;
  logic [3:0] pin_b;
  logic [4:0] pin_cas;

  ssu_sync #(
    .W(NS)
  ) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in({guard_request_input, ack_button_input, func_in_a, func_in_b,
      cascade_in}),
    .sync_out(pins_sync)
  );
  assign {pin_guard, pin_ack, pin_a, pin_b, pin_cas} = pins_sync;

  //////////////////////////////////////////////////////////////////////////
  // combinational helpers

  logic ack_edge;
  logic follower;
  logic cascading;
  logic [4:0] eff_mask;
  logic guard_req;
  logic [3:0] func_req;
  logic [NUM_EV_W-1:0] cause;
  logic [NUM_EV_W-1:0] ev_set;
  logic [1:0] ev_cls [NUM_EV_W];
  logic [4:0] active_all;

  always_comb begin
    ack_edge = pin_ack & ~st_reg.ack_prev;
    follower = st_reg.cas_sel == ssu_pkg::CAS_FOLLOWER;
    cascading = follower | (st_reg.cas_sel == ssu_pkg::CAS_MASTER);
    // guard can only ride the chain when a fieldbus is fitted
    eff_mask = {st_reg.chain_mask[4] & st_reg.fb_present,
      st_reg.chain_mask[3:0]}; // RULE6
    guard_req = (st_reg.guard_local_en & pin_guard)
      | (st_reg.guard_fb_en & fb_guard_req) // RULE1
      | (follower & eff_mask[ssu_pkg::FN_GUARD]
        & pin_cas[ssu_pkg::FN_GUARD]); // RULE7
    func_req = pin_a | pin_b
      | ({4{st_reg.fb_present}} & fb_func_req)
      | ({4{follower}} & eff_mask[3:0] & pin_cas[3:0]); // RULE7
    cause = {fb_passivated, limit_hit, stop_completed,
      st_reg.func_latch[2:0]};
    ev_set = cause & ~st_reg.cause_prev;
    for (int i = 0; i < NUM_EV_W; i++) begin
      if (i < ssu_pkg::EV_COMP_BASE + 3) begin
        ev_cls[i] = st_reg.cls_req; // RULE12
      end else if (i < ssu_pkg::EV_PASSIVATED) begin
        ev_cls[i] = st_reg.cls_lim; // RULE13
      end else begin
        ev_cls[i] = st_reg.cls_pas; // RULE14
      end
    end
    active_all = {guard_output, func_active};
  end

  // output follows the request with no register in the path
  assign guard_output = guard_req | st_reg.guard_hold; // RULE2
  assign func_active = func_req | st_reg.func_latch;
  assign drive_inhibit = guard_output
    | func_active[ssu_pkg::FN_TORQUE]; // RULE4
  assign start_refused = drive_start_cmd & drive_inhibit; // RULE4

  //////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic found;
    logic is_fault;
    logic [31:0] stat;
    found = 1'b0;
    is_fault = 1'b0;
    stat = '0;
    st_next = st_reg;

    // millisecond and blink enables
    st_next.ms_tick = 1'b0;
    if (st_reg.ms_cnt == MSW'(MS_CYCLES - 1)) begin
      st_next.ms_cnt = '0;
      st_next.ms_tick = 1'b1;
    end else begin
      st_next.ms_cnt = st_reg.ms_cnt + MSW'(1);
    end
    if (st_reg.ms_tick) begin
      if (st_reg.blink_cnt == 16'(BLINK_HALF_MS - 1)) begin
        st_next.blink_cnt = '0;
        st_next.blink = ~st_reg.blink;
      end else begin
        st_next.blink_cnt = st_reg.blink_cnt + 16'h0001;
      end
    end

    // start guard
    st_next.ack_prev = pin_ack;
    if (guard_req) begin
      st_next.guard_hold = 1'b1;
    end else if (!st_reg.guard_ack_manual || ack_edge) begin
      st_next.guard_hold = 1'b0; // RULE5
    end
    if (guard_output) begin
      if (st_reg.ms_tick && st_reg.guard_cnt < st_reg.guard_delay) begin
        st_next.guard_cnt = st_reg.guard_cnt + 16'h0001;
      end
      st_next.guard_done = st_reg.guard_cnt >= st_reg.guard_delay; // RULE3
    end else begin
      st_next.guard_cnt = '0;
      st_next.guard_done = 1'b0; // RULE5
    end
    if (!st_next.guard_hold && !guard_req) begin
      st_next.guard_done = 1'b0; // RULE5
    end

    // function latches; a follower in automatic mode releases with master
    for (int i = 0; i < ssu_pkg::NUM_DUAL; i++) begin
      st_next.func_latch[i] = func_req[i] | (st_reg.func_latch[i]
        & st_reg.func_ack_manual & ~ack_edge); // RULE8
    end
    st_next.cas_out = {5{cascading}} & eff_mask & active_all; // RULE7

    // events: pending set wins over the service clear
    st_next.cause_prev = cause;
    st_next.ev_valid = 1'b0;
    st_next.pend = st_reg.pend;
    for (int i = 0; i < NUM_EV_W; i++) begin
      if (!found && st_reg.pend[i]) begin
        found = 1'b1;
        st_next.pend[i] = 1'b0;
        st_next.ev_valid = 1'b1; // RULE9
        st_next.ev_code = 4'(i);
        st_next.ev_class = ev_cls[i];
      end
      if (ev_set[i] && ev_cls[i] != ssu_pkg::CLS_EVENT
          && ev_cls[i] != ssu_pkg::CLS_WARN) begin
        is_fault = 1'b1;
      end
    end
    st_next.pend = st_next.pend | ev_set;

    // warnings follow their causes, nothing latches
    st_next.warn = 1'b0;
    for (int i = 0; i < NUM_EV_W; i++) begin
      if (cause[i] && ev_cls[i] == ssu_pkg::CLS_WARN) begin
        st_next.warn = 1'b1; // RULE10
      end
    end

    if (bus_wr && bus_addr == ssu_pkg::ADDR_RECOVER
        && bus_wdata[ssu_pkg::RECOVER_BIT]) begin
      st_next.fault = 1'b0;
    end
    if (is_fault) begin
      st_next.fault = 1'b1; // RULE11
    end

    // register writes
    if (bus_wr) begin
      case (bus_addr)
        ssu_pkg::ADDR_CTRL: begin
          st_next.mode = bus_wdata[ssu_pkg::CTRL_MODE_LSB +: 3];
          st_next.fb_present = bus_wdata[ssu_pkg::CTRL_FB_PRESENT];
          st_next.guard_local_en = bus_wdata[ssu_pkg::CTRL_GUARD_LOCAL_EN];
          st_next.guard_fb_en = bus_wdata[ssu_pkg::CTRL_GUARD_FB_EN];
          st_next.guard_ack_manual =
            bus_wdata[ssu_pkg::CTRL_GUARD_ACK_MANUAL];
          st_next.func_ack_manual = bus_wdata[ssu_pkg::CTRL_FUNC_ACK_MANUAL];
        end
        ssu_pkg::ADDR_GUARD_DELAY: begin
          st_next.guard_delay = bus_wdata[15:0];
        end
        ssu_pkg::ADDR_CASCADE: begin
          st_next.cas_sel = bus_wdata[ssu_pkg::CAS_SEL_LSB +: 2];
          st_next.chain_mask = bus_wdata[ssu_pkg::CAS_MASK_LSB +: 5];
        end
        ssu_pkg::ADDR_EVCLASS: begin
          st_next.cls_req = bus_wdata[ssu_pkg::CLS_REQ_LSB +: 2];
          st_next.cls_lim = bus_wdata[ssu_pkg::CLS_LIM_LSB +: 2];
          st_next.cls_pas = bus_wdata[ssu_pkg::CLS_PAS_LSB +: 2];
        end
        default: begin
        end
      endcase
    end

    // register reads, data valid the next cycle only
    stat = {12'h000, pin_cas, st_reg.func_latch, st_reg.warn,
      st_reg.fault, st_reg.guard_done, st_reg.guard_hold, func_active,
      st_reg.mode};
    st_next.rdata = '0;
    if (bus_rd) begin
      case (bus_addr)
        ssu_pkg::ADDR_CTRL: begin
          st_next.rdata = {24'h000000, st_reg.func_ack_manual,
            st_reg.guard_ack_manual, st_reg.guard_fb_en,
            st_reg.guard_local_en, st_reg.fb_present, st_reg.mode};
        end
        ssu_pkg::ADDR_GUARD_DELAY: begin
          st_next.rdata = {16'h0000, st_reg.guard_delay};
        end
        ssu_pkg::ADDR_CASCADE: begin
          st_next.rdata = {19'h00000, st_reg.chain_mask, 6'h00,
            st_reg.cas_sel};
        end
        ssu_pkg::ADDR_EVCLASS: begin
          st_next.rdata = {26'h0000000, st_reg.cls_pas, st_reg.cls_lim,
            st_reg.cls_req};
        end
        ssu_pkg::ADDR_STATUS: begin
          st_next.rdata = stat;
        end
        default: begin
          st_next.rdata = '0;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.fb_present <= ssu_pkg::CTRL_RESET[ssu_pkg::CTRL_FB_PRESENT];
      st_reg.guard_local_en <=
        ssu_pkg::CTRL_RESET[ssu_pkg::CTRL_GUARD_LOCAL_EN];
      st_reg.guard_delay <= ssu_pkg::GUARD_DELAY_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs and indicators

  assign bus_rdata = st_reg.rdata;
  assign guard_completed_output = st_reg.guard_done; // RULE3
  assign cascade_out = st_reg.cas_out;
  assign event_valid = st_reg.ev_valid;
  assign event_code = st_reg.ev_code;
  assign event_class = st_reg.ev_class;
  assign warning_active = st_reg.warn; // RULE10
  assign drive_trip = st_reg.fault; // RULE11

  logic is_cfg;
  logic is_fs;
  assign is_cfg = st_reg.mode == ssu_pkg::MODE_CONFIG;
  assign is_fs = st_reg.mode == ssu_pkg::MODE_FAILSAFE;

  always_comb begin
    case (st_reg.mode)
      ssu_pkg::MODE_OPER, ssu_pkg::MODE_SAFE: run_led = 1'b1; // RULE15
      ssu_pkg::MODE_CONFIG, ssu_pkg::MODE_STARTUP: run_led = st_reg.blink;
      default: run_led = 1'b0; // RULE15
    endcase
    fs_led_red = is_fs | (is_cfg & st_reg.blink); // RULE16
    if (is_fs || is_cfg) begin
      fs_led_green = 1'b0;
    end else if (|func_req || guard_req) begin
      // only a live request is steady; a held latch must flash instead
      fs_led_green = 1'b1; // RULE16
    end else if (|(st_reg.func_latch & ~func_req) || st_reg.guard_hold) begin
      fs_led_green = st_reg.blink; // RULE16
    end else begin
      fs_led_green = 1'b0;
    end
    case (fb_state)
      ssu_pkg::FB_READY: fb_led = 1'b1; // RULE17
      ssu_pkg::FB_RUNNING: fb_led = st_reg.blink; // RULE17
      default: fb_led = 1'b0; // RULE17
    endcase
  end
endmodule : ssu_unit
`default_nettype wire

// ### inc/ssu_pkg.sv
// constants and types shared by the safety status and event unit
`default_nettype none
package ssu_pkg;
  // timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned MS_NS = 1000000;
  localparam int unsigned MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam int unsigned BLINK_HALF_MS = 250;

  // register map, byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_GUARD_DELAY = 8'h04;
  localparam logic [7:0] ADDR_CASCADE = 8'h08;
  localparam logic [7:0] ADDR_EVCLASS = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_RECOVER = 8'h14;

  // control register fields
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_FB_PRESENT = 3;
  localparam int unsigned CTRL_GUARD_LOCAL_EN = 4;
  localparam int unsigned CTRL_GUARD_FB_EN = 5;
  localparam int unsigned CTRL_GUARD_ACK_MANUAL = 6;
  localparam int unsigned CTRL_FUNC_ACK_MANUAL = 7;
  // cascade register fields
  localparam int unsigned CAS_SEL_LSB = 0;
  localparam int unsigned CAS_MASK_LSB = 8;
  // event class register fields
  localparam int unsigned CLS_REQ_LSB = 0;
  localparam int unsigned CLS_LIM_LSB = 2;
  localparam int unsigned CLS_PAS_LSB = 4;
  // recovery register field
  localparam int unsigned RECOVER_BIT = 0;

  // reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0018;
  localparam logic [15:0] GUARD_DELAY_RESET = 16'h0000;

  // function indices
  localparam int unsigned FN_TORQUE = 0;
  localparam int unsigned FN_STOP1 = 1;
  localparam int unsigned FN_ESTOP = 2;
  localparam int unsigned FN_LSPEED1 = 3;
  localparam int unsigned FN_GUARD = 4;
  localparam int unsigned NUM_DUAL = 4;
  localparam int unsigned NUM_FN = 5;

  // event codes: requests 0..2, completions 3..5, limits 6..13, passivation 14
  localparam int unsigned EV_COMP_BASE = 3;
  localparam int unsigned EV_LIM_BASE = 6;
  localparam int unsigned NUM_LIMITS = 8;
  localparam int unsigned EV_PASSIVATED = 14;
  localparam int unsigned NUM_EV = 15;

  typedef enum logic [2:0] {
    MODE_CONFIG, MODE_STARTUP, MODE_OPER, MODE_SAFE, MODE_FAILSAFE
  } ssu_mode_e;

  typedef enum logic [1:0] {
    CLS_EVENT, CLS_WARN, CLS_FAULT
  } ssu_class_e;

  typedef enum logic [1:0] {
    CAS_NONE, CAS_MASTER, CAS_FOLLOWER
  } ssu_cas_e;

  typedef enum logic [1:0] {
    FB_STOPPED, FB_READY, FB_RUNNING
  } ssu_fb_e;
endpackage : ssu_pkg
`default_nettype wire

// ### logic/ssu_sync.sv
// two-flop synchroniser for a group of pin inputs
`default_nettype none
module ssu_sync #(
  parameter int unsigned W = 1
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } ssu_sync_s;

  ssu_sync_s st_reg;
  ssu_sync_s st_next;

  always_comb begin
    st_next.stage1 = async_in;
    st_next.stage2 = st_reg.stage1;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sync_out = st_reg.stage2;
endmodule : ssu_sync
`default_nettype wire

// ### test/ssu_fb_model.sv
// fieldbus controller model for the safety link side of the unit
`default_nettype none
module ssu_fb_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic link_run,
  input wire logic guard_cmd,
  input wire logic pass_cmd,
  output logic fb_guard_req,
  output logic [3:0] fb_func_req,
  output logic [1:0] fb_state,
  output logic fb_passivated
);
  // the controller changes its levels just after an edge, like real logic
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fb_guard_req <= 1'b0;
      fb_func_req <= 4'h0;
      fb_state <= 2'h0;
      fb_passivated <= 1'b0;
    end else begin
      fb_guard_req <= guard_cmd;
      fb_passivated <= pass_cmd;
      fb_func_req <= 4'h0;
      // ready one cycle before running, stopped when the link drops
      if (!link_run) begin
        fb_state <= ssu_pkg::FB_STOPPED;
      end else if (fb_state == ssu_pkg::FB_STOPPED) begin
        fb_state <= ssu_pkg::FB_READY;
      end else begin
        fb_state <= ssu_pkg::FB_RUNNING;
      end
    end
  end
endmodule : ssu_fb_model
`default_nettype wire

// ### test/ssu_unit_chk.sv
// port-level assertions for the safety status and event unit
`default_nettype none
module ssu_unit_chk #(
  parameter int unsigned MS_CYCLES = ssu_pkg::MS_CYCLES,
  parameter int unsigned BLINK_HALF_MS = ssu_pkg::BLINK_HALF_MS
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic drive_start_cmd,
  input wire logic guard_output,
  input wire logic guard_completed_output,
  input wire logic drive_inhibit,
  input wire logic start_refused,
  input wire logic event_valid,
  input wire logic [1:0] event_class,
  input wire logic drive_trip
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic rec_w;
  assign rec_w = bus_wr && bus_addr == ssu_pkg::ADDR_RECOVER
    && bus_wdata[ssu_pkg::RECOVER_BIT];
  sequence s_done_rise;
    $rose(guard_completed_output);
  endsequence
  sequence s_guard_drop;
    $fell(guard_output);
  endsequence
  AST_INHIBIT: assert property (guard_output |-> drive_inhibit)
    else $error("guard active without inhibit");
  AST_REFUSE: assert property (start_refused ==
    (drive_start_cmd && drive_inhibit)) else $error("start refusal wrong");
  AST_DONE_IN: assert property (
    guard_completed_output |-> guard_output)
    else $error("completed without guard");
  AST_DONE_LATE: assert property (s_done_rise |-> $past(guard_output))
    else $error("completed without delay");
  AST_CLEAR: assert property (s_guard_drop |-> !guard_completed_output)
    else $error("completed outlived guard");
  AST_FAULT_TRIP: assert property (event_valid && event_class[1]
    |-> drive_trip) else $error("fault without trip");
  AST_FAULT_HOLD: assert property (drive_trip && !rec_w &&
    !$past(rec_w) |=> drive_trip) else $error("trip dropped early");
  AST_WARN_NOTRIP: assert property (event_valid &&
    event_class == 2'h1 && !$past(drive_trip) |-> !drive_trip)
    else $error("warning tripped drive");
endmodule : ssu_unit_chk
bind ssu_unit ssu_unit_chk #(.MS_CYCLES(MS_CYCLES),
  .BLINK_HALF_MS(BLINK_HALF_MS)) chk_u (.mclk, .rst_n, .bus_addr,
  .bus_wdata, .bus_wr, .drive_start_cmd, .guard_output,
  .guard_completed_output, .drive_inhibit, .start_refused, .event_valid,
  .event_class, .drive_trip);
`default_nettype wire

// ### test/tb_ssu_unit.sv
// self-checking bench for the safety status and event unit
`default_nettype none
module tb_ssu_unit;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst_n, bus_wr, bus_rd, guard_request_input, ack_button_input;
  logic drive_start_cmd, fb_guard_req, fb_passivated, guard_output;
  logic guard_completed_output, drive_inhibit, start_refused, event_valid;
  logic warning_active, drive_trip, link_run, guard_cmd, pass_cmd;
  logic run_led, fs_led_green, fs_led_red, fb_led;
  logic [7:0] bus_addr, limit_hit;
  logic [31:0] bus_wdata, bus_rdata;
  logic [3:0] func_in_a, func_in_b, fb_func_req, func_active, event_code;
  logic [4:0] cascade_out, cascade_in;
  logic [1:0] fb_state, event_class;
  logic [2:0] stop_completed;
  int err_total, check_count, cyc, n;
  ssu_unit #(.MS_CYCLES(10), .BLINK_HALF_MS(2)) dut_u (.mclk, .rst_n,
    .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata,
    .guard_request_input, .ack_button_input, .func_in_a, .func_in_b,
    .cascade_in, .cascade_out, .fb_guard_req, .fb_func_req,
    .fb_state, .fb_passivated, .stop_completed, .limit_hit,
    .drive_start_cmd, .guard_output, .guard_completed_output,
    .drive_inhibit, .start_refused, .func_active, .event_valid,
    .event_code, .event_class, .warning_active, .drive_trip, .run_led,
    .fs_led_green, .fs_led_red, .fb_led);
  ssu_fb_model fb_u (.mclk, .rst_n, .link_run, .guard_cmd, .pass_cmd,
    .fb_guard_req, .fb_func_req, .fb_state, .fb_passivated);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge mclk);
    bus_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge mclk);
    bus_rd <= 1'b0;
    #1;
    chk("rdata", e, bus_rdata);
  endtask : rd
  task automatic step(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask : step
  // waits a bounded time for one report and checks its code and class
  task automatic wait_ev(input logic [3:0] c, input logic [1:0] k);
    int i;
    i = 0;
    step(1);
    while (event_valid !== 1'b1 && i < 30) begin
      step(1);
      i++;
    end
    chk("event_valid", 32'h1, {31'h0, event_valid});
    chk("event_code", {28'h0, c}, {28'h0, event_code});
    chk("event_class", {30'h0, k}, {30'h0, event_class});
  endtask : wait_ev
  task automatic results;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results
  // a hang is cut short well beyond the few hundred cycles needed
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      results;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, bus_wr, bus_rd, guard_request_input, ack_button_input} = '0;
    {drive_start_cmd, link_run, guard_cmd, pass_cmd} = '0;
    {bus_addr, limit_hit, bus_wdata, func_in_a, func_in_b} = '0;
    {stop_completed, cascade_in} = '0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    rd(ssu_pkg::ADDR_CTRL, ssu_pkg::CTRL_RESET);
    rd(ssu_pkg::ADDR_GUARD_DELAY, 32'h0000_0000);
    rd(8'h3C, 32'h0000_0000);
    wr(ssu_pkg::ADDR_STATUS, 32'hFFFF_FFFF);
    rd(ssu_pkg::ADDR_STATUS, 32'h0000_0000);
    // fieldbus guard request, automatic release, 2 ms completion delay
    link_run <= 1'b1;
    wr(ssu_pkg::ADDR_CTRL, 32'h0000_0038);
    wr(ssu_pkg::ADDR_GUARD_DELAY, 32'h0000_0002);
    @(posedge mclk);
    guard_cmd <= 1'b1;
    drive_start_cmd <= 1'b1;
    step(1);
    chk("guard_output", 32'h1, {31'h0, guard_output});
    chk("drive_inhibit", 32'h1, {31'h0, drive_inhibit});
    chk("start_refused", 32'h1, {31'h0, start_refused});
    n = 0;
    while (guard_completed_output !== 1'b1 && n < 40) begin
      step(1);
      n++;
    end
    chk("done_delay", 32'h1, {31'h0, n >= 10 && n <= 25});
    @(posedge mclk);
    guard_cmd <= 1'b0;
    step(3);
    chk("guard_off", 32'h0, {31'h0, guard_output});
    chk("done_off", 32'h0, {31'h0, guard_completed_output});
    chk("start_ok", 32'h0, {31'h0, start_refused});
    // local pin request with manual acknowledge
    wr(ssu_pkg::ADDR_CTRL, 32'h0000_0058);
    @(posedge mclk);
    guard_request_input <= 1'b1;
    step(4);
    chk("guard_pin", 32'h1, {31'h0, guard_output});
    @(posedge mclk);
    guard_request_input <= 1'b0;
    step(8);
    chk("guard_unacked", 32'h1, {31'h0, guard_output});
    @(posedge mclk);
    ack_button_input <= 1'b1;
    step(4);
    @(posedge mclk);
    ack_button_input <= 1'b0;
    step(4);
    chk("guard_acked", 32'h0, {31'h0, guard_output});
    // requests reported as warnings, limits as faults, passivation as event
    wr(ssu_pkg::ADDR_CTRL, 32'h0000_0018);
    wr(ssu_pkg::ADDR_EVCLASS, 32'h0000_0009);
    @(posedge mclk);
    func_in_a <= 4'h2;
    func_in_b <= 4'h2;
    wait_ev(4'h1, ssu_pkg::CLS_WARN);
    step(2);
    chk("warn_on", 32'h1, {31'h0, warning_active});
    chk("warn_trip", 32'h0, {31'h0, drive_trip});
    @(posedge mclk);
    stop_completed <= 3'h2;
    wait_ev(4'h4, ssu_pkg::CLS_WARN);
    @(posedge mclk);
    {func_in_a, func_in_b} <= 8'h00;
    stop_completed <= 3'h0;
    step(10);
    chk("warn_off", 32'h0, {31'h0, warning_active});
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk);
      limit_hit <= 8'h01 << i;
      wait_ev(4'(6 + i), ssu_pkg::CLS_FAULT);
      @(posedge mclk);
      limit_hit <= 8'h00;
      step(2);
    end
    step(5);
    chk("trip_held", 32'h1, {31'h0, drive_trip});
    wr(ssu_pkg::ADDR_RECOVER, 32'h0000_0001);
    step(3);
    chk("trip_clear", 32'h0, {31'h0, drive_trip});
    @(posedge mclk);
    pass_cmd <= 1'b1;
    wait_ev(4'hE, ssu_pkg::CLS_EVENT);
    step(3);
    chk("pass_trip", 32'h0, {31'h0, drive_trip});
    // config mode: run, red and fieldbus indicators flash on the shared blink, toggling every 20 cycles
    n = run_led;
    step(20);
    chk("run_flash", {31'h0, ~n[0]}, {31'h0, run_led});
    chk("red_flash", {31'h0, ~n[0]}, {31'h0, fs_led_red});
    chk("fb_flash", {31'h0, ~n[0]}, {31'h0, fb_led});
    link_run <= 1'b0;
    step(2);
    chk("fb_off", 32'h0, {31'h0, fb_led});
    link_run <= 1'b1;
    step(1);
    chk("fb_ready", 32'h1, {31'h0, fb_led});
    wr(ssu_pkg::ADDR_CTRL, 32'h0000_009A);
    @(posedge mclk);
    func_in_b <= 4'h2;
    step(4);
    chk("run_oper", 32'h1, {31'h0, run_led});
    chk("fs_active", 32'h1, {31'h0, fs_led_green});
    @(posedge mclk);
    func_in_b <= 4'h0;
    step(4);
    n = fs_led_green;
    step(20);
    chk("fs_unacked", {31'h0, ~n[0]}, {31'h0, fs_led_green});
    wr(ssu_pkg::ADDR_CTRL, 32'h0000_001C);
    step(1);
    chk("run_fs", 32'h0, {31'h0, run_led});
    chk("red_fs", 32'h1, {31'h0, fs_led_red});
    // master without fieldbus forwards only dual-input functions
    wr(ssu_pkg::ADDR_CTRL, 32'h0000_0010);
    wr(ssu_pkg::ADDR_CASCADE, 32'h0000_1F01);
    @(posedge mclk);
    func_in_a <= 4'h1;
    guard_request_input <= 1'b1;
    step(5);
    chk("cas_nofb", 32'h01, {27'h0, cascade_out});
    wr(ssu_pkg::ADDR_CTRL, 32'h0000_0018);
    step(2);
    chk("cas_fb", 32'h11, {27'h0, cascade_out});
    @(posedge mclk);
    {func_in_a, guard_request_input} <= 5'h00;
    wr(ssu_pkg::ADDR_CASCADE, 32'h0000_1F02);
    @(posedge mclk);
    cascade_in <= 5'h14;
    step(4);
    chk("fol_func", 32'h4, {28'h0, func_active});
    chk("fol_guard", 32'h1, {31'h0, guard_output});
    chk("fol_fwd", 32'h14, {27'h0, cascade_out});
    @(posedge mclk);
    cascade_in <= 5'h00;
    step(4);
    chk("fol_ack", 32'h0, {28'h0, func_active});
    results;
  end
endmodule : tb_ssu_unit
`default_nettype wire
